// file: verilog/adcsr_consts.vh
// Purpose: Constants for the converter status, special channel and port block
// Assumes: Avalon-MM word addressing, one register per 32-bit word
// Notes:   Byte address is four times the printed register index
`ifndef ADCSR_CONSTS_VH
`define ADCSR_CONSTS_VH

// =====================================================
// Register indices as printed
`define ADCSR_IDX_SPECIAL_TEST   8'h09
`define ADCSR_IDX_FLAG_STATUS    8'h0b
`define ADCSR_IDX_INPUT_GATE     8'h0d
`define ADCSR_IDX_PIN_READBACK   8'h0f
// Registers of this block's own layout
`define ADCSR_IDX_CONTROL        8'h20
`define ADCSR_IDX_IRQ_STATUS     8'h21
`define ADCSR_IDX_IRQ_MASK       8'h22
`define ADCSR_IDX_MUX_STATE      8'h23

// =====================================================
// Field positions
`define ADCSR_SPECIAL_BIT        0
`define ADCSR_CTRL_FAST_BIT      0
`define ADCSR_IRQ_DONE_BIT       0
`define ADCSR_IRQ_START_BIT      1
`define ADCSR_IRQ_RSVD_BIT       2

// =====================================================
// Reset values
`define ADCSR_RST_SPECIAL        1'b0
`define ADCSR_RST_GATE           8'h00
`define ADCSR_RST_PORT           8'hff
`define ADCSR_RST_FLAGS          8'h00

// =====================================================
// Channel select coding with special channels on
`define ADCSR_SEL_REF_HIGH       3'b100
`define ADCSR_SEL_REF_LOW        3'b101
`define ADCSR_SEL_REF_MID        3'b110

// Mux source codes
`define ADCSR_SRC_PIN            2'b00
`define ADCSR_SRC_REF_HIGH       2'b01
`define ADCSR_SRC_REF_LOW        2'b10
`define ADCSR_SRC_REF_MID        2'b11

// Bus answer latency, in clock cycles
`define ADCSR_WAIT_CYCLES        1

`endif

// file: verilog/adcsr_sync.v
// Purpose: Two-stage synchroniser for the shared input pins
// Assumes: Pins are asynchronous to clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
module adcsr_sync
(
	input  wire       clk,
	input  wire       reset_n,
	input  wire [7:0] async_in,
	output reg  [7:0] sync_out
);

	reg [7:0] stage1;

	// =====================================================
	// Synchroniser
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stage1   <= 8'h00;
			sync_out <= 8'h00;
		end
		else
		begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule // adcsr_sync

// file: verilog/adcsr_mux_decode.v
// Purpose: Decode the channel select into a converter source
// Assumes: Select and special enable come from registers on clk
// Notes:   Reserved codes flag an error, keep the pin source code and select no pin
`timescale 1ns/10ps
`include "adcsr_consts.vh"
module adcsr_mux_decode
(
	input  wire       special_channel_enable,
	input  wire [2:0] channel_select,
	output reg  [1:0] mux_source,
	output reg  [7:0] pin_onehot,
	output reg        reserved_select
);

	// =====================================================
	// Decode
	always @*
	begin
		mux_source      = `ADCSR_SRC_PIN;
		pin_onehot      = 8'h00;
		reserved_select = 1'b0;
		if (!special_channel_enable)
		begin
			pin_onehot = 8'h01 << channel_select;
		end
		else if (channel_select == `ADCSR_SEL_REF_HIGH)
		begin
			mux_source = `ADCSR_SRC_REF_HIGH;
		end
		else if (channel_select == `ADCSR_SEL_REF_LOW)
		begin
			mux_source = `ADCSR_SRC_REF_LOW;
		end
		else if (channel_select == `ADCSR_SEL_REF_MID)
		begin
			mux_source = `ADCSR_SRC_REF_MID;
		end
		else
		begin
			reserved_select = 1'b1;
		end
	end

endmodule // adcsr_mux_decode

// file: verilog/adcsr_regs.v
// Purpose: Status, special channel and port register bank of a converter
// Assumes: Avalon-MM slave, 32-bit data, word address = printed index
// Notes:   Conversion engine and result registers sit outside this block
`timescale 1ns/10ps
`include "adcsr_consts.vh"

// Overview of operation
// - Special enable turns select into reference choice
// - Codes 100/101/110 pick high, low, midpoint
// - Test register reads back special enable bit
// - Done flag x set at conversion x
// - Start register write clears all done flags except those set in that cycle
// - Slow clear: status read then result read
// - Fast clear: result read alone clears flag
// - Status and port data ignore writes
// - Gate bit enables pin digital buffer
// - Enabled pin reads its present level
// - Disabled pin reads as one
// - Reset presets port data to ones
// - Normal select picks pin by value
module adcsr_regs
(
	input  wire        clk,
	input  wire        reset_n,
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire [7:0]  shared_input_pin,
	input  wire [7:0]  conversion_done,
	input  wire        start_control_write,
	input  wire        result_register_read,
	input  wire [2:0]  result_register_index,
	input  wire [2:0]  channel_select,
	output wire        fast_flag_clear,
	output wire        special_channel_enable,
	output wire [1:0]  mux_source,
	output wire [7:0]  pin_onehot,
	output wire        reserved_select,
	output wire [7:0]  digital_input_enable,
	output wire        irq
);

	// =====================================================
	// State
	reg         special_enable_q;
	reg         fast_clear_q;
	reg  [7:0]  input_gate;
	reg  [7:0]  pin_digital_level;
	reg  [7:0]  conversion_done_flags;
	reg  [7:0]  status_read_armed;
	reg  [2:0]  irq_status;
	reg  [2:0]  irq_mask;
	reg         answered;
	wire [7:0]  pin_sync;
	wire        access;
	wire        take;
	wire        wr_low;
	reg  [7:0]  next_flags;
	reg  [7:0]  next_armed;
	reg  [31:0] next_readdata;
	reg  [2:0]  irq_events;
	wire [7:0]  result_hit;
	reg         sel_special;
	reg         sel_status;
	reg         sel_gate;
	reg         sel_port;
	reg         sel_control;
	reg         sel_irq_status;
	reg         sel_irq_mask;
	reg         sel_mux_state;

	// =====================================================
	// Helpers
	function [7:0] adcsr_onehot;
		input [2:0] idx;
		begin
			adcsr_onehot = 8'h01 << idx;
		end
	endfunction

	function [31:0] adcsr_zext8;
		input [7:0] value;
		begin
			adcsr_zext8 = {24'h0000_00, value};
		end
	endfunction

	// =====================================================
	// Submodules
	adcsr_sync u_sync
	(
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in (shared_input_pin),
		.sync_out (pin_sync)
	);

	adcsr_mux_decode u_decode
	(
		.special_channel_enable (special_enable_q),
		.channel_select         (channel_select),
		.mux_source             (mux_source),
		.pin_onehot             (pin_onehot),
		.reserved_select        (reserved_select)
	);

	// =====================================================
	// Address decode
	// Shared by write, read and arm paths so they never disagree
	always @*
	begin
		sel_special    = 1'b0;
		sel_status     = 1'b0;
		sel_gate       = 1'b0;
		sel_port       = 1'b0;
		sel_control    = 1'b0;
		sel_irq_status = 1'b0;
		sel_irq_mask   = 1'b0;
		sel_mux_state  = 1'b0;
		if (avs_address == `ADCSR_IDX_SPECIAL_TEST)
		begin
			sel_special = 1'b1;
		end
		else if (avs_address == `ADCSR_IDX_FLAG_STATUS)
		begin
			sel_status = 1'b1;
		end
		else if (avs_address == `ADCSR_IDX_INPUT_GATE)
		begin
			sel_gate = 1'b1;
		end
		else if (avs_address == `ADCSR_IDX_PIN_READBACK)
		begin
			sel_port = 1'b1;
		end
		else if (avs_address == `ADCSR_IDX_CONTROL)
		begin
			sel_control = 1'b1;
		end
		else if (avs_address == `ADCSR_IDX_IRQ_STATUS)
		begin
			sel_irq_status = 1'b1;
		end
		else if (avs_address == `ADCSR_IDX_IRQ_MASK)
		begin
			sel_irq_mask = 1'b1;
		end
		else if (avs_address == `ADCSR_IDX_MUX_STATE)
		begin
			sel_mux_state = 1'b1;
		end
	end

	// =====================================================
	// Bus handshake
	// One wait cycle gives a registered read path
	assign access          = avs_read | avs_write;
	assign avs_waitrequest = access & ~answered;
	assign take            = access & answered;
	assign wr_low          = avs_write & take & avs_byteenable[0];

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			answered <= 1'b0;
		end
		else
		begin
			answered <= access & ~answered;
		end
	end

	assign special_channel_enable = special_enable_q;
	assign fast_flag_clear        = fast_clear_q;
	assign digital_input_enable   = input_gate;
	assign result_hit             = result_register_read ?
		adcsr_onehot(result_register_index) : 8'h00;

	// =====================================================
	// Writable registers
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			special_enable_q <= `ADCSR_RST_SPECIAL;
			input_gate       <= `ADCSR_RST_GATE;
			fast_clear_q     <= 1'b0;
			irq_mask         <= 3'b000;
		end
		else if (wr_low)
		begin
			if (sel_special)
			begin
				// Upper bits are not stored; software keeps them zero
				special_enable_q <= avs_writedata[`ADCSR_SPECIAL_BIT];
			end
			else if (sel_gate)
			begin
				input_gate <= avs_writedata[7:0];
			end
			else if (sel_control)
			begin
				fast_clear_q <= avs_writedata[`ADCSR_CTRL_FAST_BIT];
			end
			else if (sel_irq_mask)
			begin
				irq_mask <= avs_writedata[2:0];
			end
		end
	end

	// =====================================================
	// Port data
	// Gated-off pins read one so floating analog levels never leak in
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin_digital_level <= `ADCSR_RST_PORT;
		end
		else
		begin
			pin_digital_level <= (pin_sync & input_gate) | ~input_gate;
		end
	end

	// =====================================================
	// Completion flags
	always @*
	begin
		next_flags = conversion_done_flags;
		next_armed = status_read_armed;
		if (start_control_write)
		begin
			next_flags = 8'h00;
			next_armed = 8'h00;
		end
		else if (fast_clear_q)
		begin
			next_flags = next_flags & ~result_hit;
		end
		else
		begin
			next_flags = next_flags & ~(result_hit & status_read_armed);
			next_armed = next_armed & ~result_hit;
		end
		if (avs_read & take & sel_status)
		begin
			// Arm the flags held in the accept cycle, one cycle after this read latched its data
			next_armed = conversion_done_flags;
		end
		// Set wins over any clear in the same cycle
		next_flags = next_flags | conversion_done;
	end

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			conversion_done_flags <= `ADCSR_RST_FLAGS;
			status_read_armed     <= 8'h00;
		end
		else
		begin
			conversion_done_flags <= next_flags;
			status_read_armed     <= next_armed;
		end
	end

	// =====================================================
	// Interrupts
	always @*
	begin
		irq_events                      = 3'b000;
		irq_events[`ADCSR_IRQ_DONE_BIT]  = |conversion_done;
		irq_events[`ADCSR_IRQ_START_BIT] = start_control_write;
		irq_events[`ADCSR_IRQ_RSVD_BIT]  = reserved_select & start_control_write;
	end

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irq_status <= 3'b000;
		end
		else if (wr_low & sel_irq_status)
		begin
			irq_status <= (irq_status & ~avs_writedata[2:0]) | irq_events;
		end
		else
		begin
			irq_status <= irq_status | irq_events;
		end
	end

	assign irq = |(irq_status & irq_mask);

	// =====================================================
	// Read path
	// Status and port data have no write branch above
	always @*
	begin
		next_readdata = 32'h0000_0000;
		if (sel_special)
		begin
			next_readdata = adcsr_zext8({7'h00, special_enable_q});
		end
		else if (sel_status)
		begin
			next_readdata = adcsr_zext8(conversion_done_flags);
		end
		else if (sel_gate)
		begin
			next_readdata = adcsr_zext8(input_gate);
		end
		else if (sel_port)
		begin
			next_readdata = adcsr_zext8(pin_digital_level);
		end
		else if (sel_control)
		begin
			next_readdata = adcsr_zext8({7'h00, fast_clear_q});
		end
		else if (sel_irq_status)
		begin
			next_readdata = adcsr_zext8({5'h00, irq_status});
		end
		else if (sel_irq_mask)
		begin
			next_readdata = adcsr_zext8({5'h00, irq_mask});
		end
		else if (sel_mux_state)
		begin
			next_readdata = adcsr_zext8({3'h0, reserved_select, mux_source,
				special_enable_q, fast_clear_q});
		end
	end

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			avs_readdata <= 32'h0000_0000;
		end
		else if (avs_read & ~answered)
		begin
			avs_readdata <= next_readdata;
		end
	end

endmodule // adcsr_regs

// file: verif/adcsr_pin_model.sv
// Purpose: Eight shared input pins seen by the bank
// Assumes: Bench sets levels after a clock edge
// Notes:   Pins always driven, no float
`timescale 1ns/10ps
module adcsr_pin_model
(
	input  wire logic [7:0] level,
	output logic      [7:0] pin
);
	assign pin = level;
endmodule // adcsr_pin_model

// file: verif/adcsr_checker.sv
// Purpose: Port checks of the register bank
// Assumes: One clock, async reset
// Notes:   Pin level checked only after pins sat still
`timescale 1ns/10ps
module adcsr_checker
(
	input wire        clk,
	input wire        reset_n,
	input wire [7:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0]  avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire [7:0]  shared_input_pin,
	input wire [2:0]  channel_select,
	input wire        special_channel_enable,
	input wire [1:0]  mux_source,
	input wire [7:0]  pin_onehot,
	input wire        reserved_select,
	input wire [7:0]  digital_input_enable
);
	// =====================
	// Helpers
	// Synchroniser lag makes fresh pin changes unreadable
	reg [2:0] stab;
	reg [7:0] pin_prev;
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stab     <= 3'h0;
			pin_prev <= 8'h00;
		end
		else
		begin
			pin_prev <= shared_input_pin;
			stab     <= (shared_input_pin != pin_prev) ? 3'h0 : stab + {2'h0, stab != 3'h7};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_rd(a); avs_read && !avs_waitrequest && avs_address == a; endsequence
	sequence s_wr(a);
		avs_write && !avs_waitrequest && avs_address == a && avs_byteenable[0];
	endsequence
	// =====================
	// Properties
	property p_gate_off;
		s_rd(8'h0f) |-> (avs_readdata[7:0] | digital_input_enable) == 8'hff;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("Gated pin bit not one");
	property p_pin_lvl;
		s_rd(8'h0f) ##0 stab == 3'h7 |->
			((avs_readdata[7:0] ^ shared_input_pin) & digital_input_enable) == 8'h00;
	endproperty
	a_pin_lvl: assert property (p_pin_lvl) else $error("Pin level wrong");
	property p_test_rd; s_rd(8'h09) |-> avs_readdata[0] == special_channel_enable; endproperty
	a_test_rd: assert property (p_test_rd) else $error("Special bit readback");
	property p_test_wr;
		s_wr(8'h09) |=> special_channel_enable == $past(avs_writedata[0]);
	endproperty
	a_test_wr: assert property (p_test_wr) else $error("Special bit write");
	property p_gate_wr;
		s_wr(8'h0d) |=> digital_input_enable == $past(avs_writedata[7:0]);
	endproperty
	a_gate_wr: assert property (p_gate_wr) else $error("Gate write");
	property p_reset;
		$rose(reset_n) |-> !special_channel_enable && digital_input_enable == 8'h00;
	endproperty
	a_reset: assert property (p_reset) else $error("Reset values");
	property p_ref;
		special_channel_enable && channel_select[2] && channel_select != 3'h7 |->
			!reserved_select && mux_source == channel_select[1:0] + 2'h1;
	endproperty
	a_ref: assert property (p_ref) else $error("Reference select");
	property p_rsvd;
		special_channel_enable && (!channel_select[2] || channel_select == 3'h7) |->
			reserved_select && pin_onehot == 8'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("Reserved code");
	property p_pin_sel;
		!special_channel_enable |-> pin_onehot == 8'h01 << channel_select && mux_source == 2'h0;
	endproperty
	a_pin_sel: assert property (p_pin_sel) else $error("Pin select");
endmodule // adcsr_checker
bind adcsr_regs adcsr_checker u_chk (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .shared_input_pin,
	.channel_select, .special_channel_enable, .mux_source, .pin_onehot, .reserved_select,
	.digital_input_enable);

// file: verif/adc_status_special_channel_port_bench.sv
// Purpose: Self-checking bench of the register bank
// Assumes: Master waits on waitrequest, no fixed latency
// Notes:   Byte lanes other than 0 unused
`timescale 1ns/10ps
module adc_status_special_channel_port_bench;
	reg         clk, reset_n, rdq, wrq, csw, rrd;
	reg  [7:0]  adr, lvl, dn, q;
	reg  [31:0] wd;
	reg  [2:0]  cs, ri;
	wire [31:0] rd;
	wire        wq, ffc, sce, rs, irq;
	wire [1:0]  ms;
	wire [7:0]  pins, oh, den;
	integer     failures, num_checks, i;
	adcsr_pin_model u_pins (.level(lvl), .pin(pins));
	adcsr_regs DUT (.clk(clk), .reset_n(reset_n), .avs_address(adr), .avs_read(rdq),
		.avs_write(wrq), .avs_writedata(wd), .avs_byteenable(4'h1), .avs_readdata(rd),
		.avs_waitrequest(wq), .shared_input_pin(pins), .conversion_done(dn),
		.start_control_write(csw), .result_register_read(rrd), .result_register_index(ri),
		.channel_select(cs), .fast_flag_clear(ffc), .special_channel_enable(sce),
		.mux_source(ms), .pin_onehot(oh), .reserved_select(rs), .digital_input_enable(den),
		.irq(irq));
	// =====================
	// Tasks
	task final_report;
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task ck(input [7:0] e, input [7:0] g);
		num_checks = num_checks + 1;
		if (g !== e)
		begin
			failures = failures + 1;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task bus(input w, input [7:0] a, input [7:0] d);
		begin
			@(posedge clk);
			adr <= a;
			wd  <= {24'h0000_00, d};
			rdq <= !w;
			wrq <= w;
			// Request stands until waitrequest is sampled low at a rising edge
			@(posedge clk);
			while (wq !== 1'b0) @(posedge clk);
			q = rd[7:0];
			rdq <= 1'b0;
			wrq <= 1'b0;
		end
	endtask
	task rdck(input [7:0] a, input [7:0] e);
		bus(1'b0, a, 8'h00);
		ck(e, q);
	endtask
	task ev(input [7:0] m, input s, input r, input [2:0] x);
		@(posedge clk);
		dn <= m; csw <= s; rrd <= r; ri <= x;
		@(posedge clk);
		dn <= 8'h00; csw <= 1'b0; rrd <= 1'b0;
	endtask
	task ckirq(input e);
		@(negedge clk);
		ck({7'h0, e}, {7'h0, irq});
	endtask
	// =====================
	// Scenarios
	task t_reset;
		rdck(8'h09, 8'h00);
		rdck(8'h0d, 8'h00);
		rdck(8'h0f, 8'hff);
		rdck(8'h30, 8'h00);
	endtask
	task t_port;
		@(posedge clk) lvl <= 8'ha5;
		bus(1'b1, 8'h0d, 8'h0f);
		repeat (3) @(posedge clk);
		rdck(8'h0f, 8'hf5);
		bus(1'b1, 8'h0f, 8'h00);
		rdck(8'h0f, 8'hf5);
		@(posedge clk) lvl <= 8'h5a;
		repeat (3) @(posedge clk);
		rdck(8'h0f, 8'hfa);
	endtask
	task t_chan;
		bus(1'b1, 8'h09, 8'h01);
		rdck(8'h09, 8'h01);
		for (i = 0; i < 8; i = i + 1)
		begin
			@(posedge clk) cs <= i[2:0];
			@(negedge clk) ck((i < 4 || i == 7) ? 8'h04 : i[7:0] - 8'h03, {5'h0, rs, ms});
		end
		bus(1'b1, 8'h09, 8'h00);
		for (i = 0; i < 8; i = i + 1)
		begin
			@(posedge clk) cs <= i[2:0];
			@(negedge clk) ck(8'h01 << i[2:0], oh);
		end
	endtask
	task t_flags;
		ev(8'h05, 1'b0, 1'b0, 3'h0);
		rdck(8'h0b, 8'h05);
		bus(1'b1, 8'h0b, 8'hff);
		rdck(8'h0b, 8'h05);
		ev(8'h00, 1'b0, 1'b1, 3'h2);
		rdck(8'h0b, 8'h01);
		// Flag 1 set after the last status read stays put
		ev(8'h02, 1'b0, 1'b0, 3'h0);
		ev(8'h00, 1'b0, 1'b1, 3'h1);
		rdck(8'h0b, 8'h03);
		ev(8'h00, 1'b1, 1'b0, 3'h0);
		rdck(8'h0b, 8'h00);
		bus(1'b1, 8'h20, 8'h01);
		rdck(8'h20, 8'h01);
		ck(8'h01, {7'h0, ffc});
		ev(8'h80, 1'b0, 1'b0, 3'h0);
		ev(8'h00, 1'b0, 1'b1, 3'h7);
		rdck(8'h0b, 8'h00);
	endtask
	task t_irq;
		bus(1'b1, 8'h22, 8'h01);
		ckirq(1'b1);
		bus(1'b1, 8'h22, 8'h00);
		ckirq(1'b0);
		bus(1'b1, 8'h22, 8'h01);
		bus(1'b1, 8'h21, 8'h01);
		ckirq(1'b0);
		ev(8'h01, 1'b0, 1'b0, 3'h0);
		ckirq(1'b1);
		// Start with a reserved special code raises its own event
		bus(1'b1, 8'h22, 8'h04);
		bus(1'b1, 8'h21, 8'h07);
		ckirq(1'b0);
		bus(1'b1, 8'h09, 8'h01);
		@(posedge clk) cs <= 3'h0;
		ev(8'h00, 1'b1, 1'b0, 3'h0);
		ckirq(1'b1);
		rdck(8'h21, 8'h06);
		rdck(8'h23, 8'h13);
		bus(1'b1, 8'h09, 8'h00);
	endtask
	// =====================
	// Run
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial
	begin
		#100000;
		failures = failures + 1;
		final_report;
	end
	initial
	begin
		failures = 0; num_checks = 0; reset_n = 1'b0;
		{rdq, wrq, csw, rrd} = 4'h0;
		adr = 8'h00; lvl = 8'h00; dn = 8'h00; wd = 32'h0000_0000; cs = 3'h0; ri = 3'h0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		t_reset;
		t_port;
		t_chan;
		t_flags;
		t_irq;
		final_report;
	end
endmodule // adc_status_special_channel_port_bench
